// File: core/bafe_flag_if.sv
// carrier between the register top and the fault flag keeper
`timescale 1ns/1ps
`default_nettype none
interface bafe_flag_if;
  logic [5:0] set;
  logic [5:0] hold;
  logic       clr;
  logic [5:0] flags;

  modport owner  (output set, output hold, output clr, input flags);
  modport keeper (input set, input hold, input clr, output flags);
endinterface
`default_nettype wire

// File: core/bafe_flag_keeper.sv
// sticky fault flags that clear on read only once their condition is gone
`timescale 1ns/1ps
`default_nettype none
module bafe_flag_keeper (
  input  wire logic   clk,
  input  wire logic   rst,
  bafe_flag_if.keeper fl
);

  bafe_pkg::bafe_flag_s st_q;
  bafe_pkg::bafe_flag_s st_d;

  // set wins over a clear landing in the same cycle; hold blocks the clear
  always_comb begin
    st_d       = st_q;
    st_d.flags = fl.set | (st_q.flags & ~({6{fl.clr}} & ~fl.hold));
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q.flags <= bafe_pkg::FLAGS_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign fl.flags = st_q.flags;

endmodule
`default_nettype wire

// File: core/bafe_pkg.sv
// constants and state types for the battery front-end status and monitor-select registers
package bafe_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PART_AND_WAKE_STATUS_OFS          = 8'h00;
  localparam logic [7:0] PROTECTION_FAULT_STATUS_OFS       = 8'h01;
  localparam logic [7:0] MONITOR_SELECT_AND_USER_FLAGS_OFS = 8'h03;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PART_KIND_FLAG_BIT             = 5;
  localparam int WAKE_PIN_LEVEL_STATUS_BIT      = 4;
  localparam int EXTERNAL_OVERTEMP_FLAG_BIT     = 5;
  localparam int INTERNAL_OVERTEMP_FLAG_BIT     = 4;
  localparam int LOAD_FAIL_FLAG_BIT             = 3;
  localparam int DISCHARGE_SHORT_FLAG_BIT       = 2;
  localparam int DISCHARGE_OVERCURRENT_FLAG_BIT = 1;
  localparam int CHARGE_OVERCURRENT_FLAG_BIT    = 0;
  localparam int USER_FLAG_HIGH_BIT             = 7;
  localparam int USER_FLAG_LOW_BIT              = 6;
  localparam int MONITOR_SELECT_LSB             = 0;
  localparam int MONITOR_SELECT_W               = 4;
  localparam int FAULT_FLAG_W                   = 6;

  // ----------------------------------------------------------------
  // index of each pin input in the synchroniser vector
  // ----------------------------------------------------------------
  localparam int SYNC_W         = 7;
  localparam int SYNC_CHG_OC    = 0;
  localparam int SYNC_DIS_OC    = 1;
  localparam int SYNC_DIS_SHORT = 2;
  localparam int SYNC_HEAVY     = 3;
  localparam int SYNC_INT_OT    = 4;
  localparam int SYNC_EXT_OT    = 5;
  localparam int SYNC_WAKE      = 6;

  // ----------------------------------------------------------------
  // monitor select codes and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] MON_OFF       = 4'h0;
  localparam logic [3:0] MON_CELL_LAST = 4'h7;
  localparam logic [3:0] MON_EXT_TEMP  = 4'h8;
  localparam logic [3:0] MON_INT_TEMP  = 4'h9;
  localparam logic [7:0] RDATA_RST     = 8'h00;
  localparam logic [5:0] FLAGS_RST     = 6'h00;
  localparam logic [6:0] SYNC_RST      = 7'h00;

  typedef struct packed {
    logic [FAULT_FLAG_W-1:0] flags;
  } bafe_flag_s;

  typedef struct packed {
    logic [SYNC_W-1:0]           sync1;
    logic [SYNC_W-1:0]           sync2;
    logic [7:0]                  rdata;
    logic                        rvalid;
    logic                        user_flag_high;
    logic                        user_flag_low;
    logic [MONITOR_SELECT_W-1:0] mon_code;
    logic [MONITOR_SELECT_W-1:0] mon_route;
  } bafe_main_s;

endpackage

// File: core/bafe_status_regs.sv
// status, fault and monitor-select registers of the battery front end
`timescale 1ns/1ps
`default_nettype none
module bafe_status_regs #(
  parameter logic PART_KIND = 1'b1   // arbitrary strap value
) (
  input  wire logic       clk,
  input  wire logic       rst,
  // register port from the serial engine (same clock)
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  // settings held in registers outside this block (same clock)
  input  wire logic       wake_polarity_select,
  input  wire logic       load_monitor_enable,
  // comparator levels from the analog side (asynchronous)
  input  wire logic       wake_pin_above,
  input  wire logic       ext_overtemp_cond,
  input  wire logic       int_overtemp_cond,
  input  wire logic       load_heavy_cond,
  input  wire logic       discharge_short_cond,
  input  wire logic       discharge_overcurrent_cond,
  input  wire logic       charge_overcurrent_cond,
  // analog mux steering and user flags
  output logic      [3:0] monitor_route,
  output logic            user_flag_high,
  output logic            user_flag_low
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  bafe_pkg::bafe_main_s st_q;
  bafe_pkg::bafe_main_s st_d;

  // the flags live in their own keeper so set-over-clear priority sits in one place
  bafe_flag_if fl ();

  bafe_flag_keeper u_flags (
    .clk (clk),
    .rst (rst),
    .fl  (fl.keeper)
  );

  logic [bafe_pkg::SYNC_W-1:0] pins;
  logic                        wake_status;
  logic                        lm_armed;
  logic                        lf_set;
  logic [7:0]                  wake_reg;
  logic [7:0]                  fault_reg;
  logic [7:0]                  mon_reg;
  logic                        rd_wake;
  logic                        rd_fault;
  logic                        rd_mon;
  logic                        wr_mon;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------

  // unused codes park the mux in its low-power off state
  function automatic logic [3:0] route_of(input logic [3:0] code);
    logic [3:0] r;
    r = bafe_pkg::MON_OFF;
    if (code <= bafe_pkg::MON_CELL_LAST) begin
      r = code;
    end else if (code == bafe_pkg::MON_EXT_TEMP || code == bafe_pkg::MON_INT_TEMP) begin
      r = code;
    end else begin
      r = bafe_pkg::MON_OFF;
    end
    return r;
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  // only the control register has a write strobe; writes aimed at either
  // status offset, or at an unmapped one, fall through and change nothing
  assign rd_wake  = reg_rd & hit(reg_addr, bafe_pkg::PART_AND_WAKE_STATUS_OFS);
  assign rd_fault = reg_rd & hit(reg_addr, bafe_pkg::PROTECTION_FAULT_STATUS_OFS);
  assign rd_mon   = reg_rd & hit(reg_addr, bafe_pkg::MONITOR_SELECT_AND_USER_FLAGS_OFS);
  assign wr_mon   = reg_wr & hit(reg_addr, bafe_pkg::MONITOR_SELECT_AND_USER_FLAGS_OFS);

  // ----------------------------------------------------------------
  // fault conditions and read images
  // ----------------------------------------------------------------
  assign pins = st_q.sync2;

  // status bit reads 1 when the selected wake edge level is present
  assign wake_status = wake_polarity_select ? pins[bafe_pkg::SYNC_WAKE]
                                            : ~pins[bafe_pkg::SYNC_WAKE];

  // with the monitor off the flag neither sets nor blocks its clear
  assign lm_armed = load_monitor_enable & pins[bafe_pkg::SYNC_HEAVY];
  assign lf_set   = lm_armed & (pins[bafe_pkg::SYNC_DIS_OC]
                              | pins[bafe_pkg::SYNC_DIS_SHORT]);

  always_comb begin
    fl.set = '0;
    fl.set[bafe_pkg::EXTERNAL_OVERTEMP_FLAG_BIT]     = pins[bafe_pkg::SYNC_EXT_OT];
    fl.set[bafe_pkg::INTERNAL_OVERTEMP_FLAG_BIT]     = pins[bafe_pkg::SYNC_INT_OT];
    fl.set[bafe_pkg::LOAD_FAIL_FLAG_BIT]             = lf_set;
    fl.set[bafe_pkg::DISCHARGE_SHORT_FLAG_BIT]       = pins[bafe_pkg::SYNC_DIS_SHORT];
    fl.set[bafe_pkg::DISCHARGE_OVERCURRENT_FLAG_BIT] = pins[bafe_pkg::SYNC_DIS_OC];
    fl.set[bafe_pkg::CHARGE_OVERCURRENT_FLAG_BIT]    = pins[bafe_pkg::SYNC_CHG_OC];
    // a still-present condition keeps its flag through the read
    fl.hold = fl.set;
    // load fail survives a read only while the load stays heavy
    fl.hold[bafe_pkg::LOAD_FAIL_FLAG_BIT] = lf_set;
  end

  assign fl.clr = rd_fault;

  always_comb begin
    wake_reg = '0;
    wake_reg[bafe_pkg::PART_KIND_FLAG_BIT]        = PART_KIND;
    wake_reg[bafe_pkg::WAKE_PIN_LEVEL_STATUS_BIT] = wake_status;
  end

  always_comb begin
    fault_reg = '0;
    fault_reg[bafe_pkg::FAULT_FLAG_W-1:0] = fl.flags;
  end

  always_comb begin
    mon_reg = '0;
    mon_reg[bafe_pkg::USER_FLAG_HIGH_BIT] = st_q.user_flag_high;
    mon_reg[bafe_pkg::USER_FLAG_LOW_BIT]  = st_q.user_flag_low;
    mon_reg[bafe_pkg::MONITOR_SELECT_LSB +: bafe_pkg::MONITOR_SELECT_W] = st_q.mon_code;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d        = st_q;
    // every comparator level crosses two flops before any flag logic sees it;
    // a trip shorter than one clock period may be missed
    st_d.sync1  = {wake_pin_above, ext_overtemp_cond, int_overtemp_cond, load_heavy_cond,
                   discharge_short_cond, discharge_overcurrent_cond, charge_overcurrent_cond};
    st_d.sync2  = st_q.sync1;
    st_d.rvalid = 1'b0;

    // read data is the image before any clear caused by this read; it then
    // stands until the next read so the serial engine may shift it out slowly
    if (reg_rd) begin
      st_d.rvalid = 1'b1;
      if (rd_wake) begin
        st_d.rdata = wake_reg;
      end else if (rd_fault) begin
        st_d.rdata = fault_reg;
      end else if (rd_mon) begin
        st_d.rdata = mon_reg;
      end else begin
        st_d.rdata = bafe_pkg::RDATA_RST;
      end
    end

    // status offsets have no write path at all, so the strap stays put
    if (wr_mon) begin
      st_d.user_flag_high = reg_wdata[bafe_pkg::USER_FLAG_HIGH_BIT];
      st_d.user_flag_low  = reg_wdata[bafe_pkg::USER_FLAG_LOW_BIT];
      // reserved bits 5:4 are not stored and read back as zero
      st_d.mon_code  = reg_wdata[bafe_pkg::MONITOR_SELECT_LSB +: bafe_pkg::MONITOR_SELECT_W];
      // decoded at write time so the analog switch never sees a reserved code
      st_d.mon_route = route_of(reg_wdata[bafe_pkg::MONITOR_SELECT_LSB +:
                                          bafe_pkg::MONITOR_SELECT_W]);
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // user flags sit on the backed-up supply: only power-on reset clears them,
  // nothing in this block tied to the regulator touches them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q.sync1          <= bafe_pkg::SYNC_RST;
      st_q.sync2          <= bafe_pkg::SYNC_RST;
      st_q.rdata          <= bafe_pkg::RDATA_RST;
      st_q.rvalid         <= 1'b0;
      st_q.user_flag_high <= 1'b0;
      st_q.user_flag_low  <= 1'b0;
      st_q.mon_code       <= bafe_pkg::MON_OFF;
      st_q.mon_route      <= bafe_pkg::MON_OFF;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata      = st_q.rdata;
  assign reg_rvalid     = st_q.rvalid;
  assign monitor_route  = st_q.mon_route;
  assign user_flag_high = st_q.user_flag_high;
  assign user_flag_low  = st_q.user_flag_low;

endmodule
`default_nettype wire

// File: test/bafe_host_model.sv
// host-side model issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none
module bafe_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // strobes are one-cycle pulses; released lines show the inverse, never stale data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int i;
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    for (i = 0; i < 3 && reg_rvalid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
  endtask
endmodule
`default_nettype wire

// File: test/bafe_status_regs_monitor.sv
// assertion checker for the status and monitor-select registers
`timescale 1ns/1ps
`default_nettype none
module bafe_status_regs_monitor #(
  parameter logic PART_KIND = 1'b1
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic       wake_polarity_select,
  input wire logic       wake_pin_above,
  input wire logic       charge_overcurrent_cond,
  input wire logic [3:0] monitor_route,
  input wire logic       user_flag_high,
  input wire logic       user_flag_low
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire logic rd0 = reg_rd && reg_addr == bafe_pkg::PART_AND_WAKE_STATUS_OFS;
  wire logic rd1 = reg_rd && reg_addr == bafe_pkg::PROTECTION_FAULT_STATUS_OFS;
  wire logic wr3 = reg_wr && reg_addr == bafe_pkg::MONITOR_SELECT_AND_USER_FLAGS_OFS;

  AST_RVALID_PULSE: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  AST_RVALID_ONLY: assert property (!reg_rd |=> !reg_rvalid)
    else $error("answer without read");
  AST_PART_KIND: assert property (rd0 |=> reg_rdata[5] == PART_KIND)
    else $error("part kind bit wrong");
  AST_WAKE: assert property (rd0 && !$past(rst, 3) && $stable(wake_pin_above)
    && wake_pin_above == $past(wake_pin_above, 2) && wake_pin_above == $past(wake_pin_above, 3)
    |=> reg_rdata[4] == ($past(wake_pin_above) ~^ $past(wake_polarity_select)))
    else $error("wake status wrong");
  AST_RSVD_STATUS: assert property (rd0 |=> reg_rdata[7:6] == 2'h0 && reg_rdata[3:0] == 4'h0)
    else $error("reserved status bits set");
  AST_CHG_OC_HELD: assert property (rd1 && $past(charge_overcurrent_cond, 3)
    && $past(charge_overcurrent_cond, 2) && !$past(rst, 3) |=> reg_rdata[0])
    else $error("charge overcurrent flag missing");
  AST_ROUTE: assert property (wr3 |=> monitor_route ==
    (($past(reg_wdata[3:0]) > 4'h9) ? 4'h0 : $past(reg_wdata[3:0])))
    else $error("monitor route wrong");
  AST_ROUTE_HOLD: assert property (!wr3 |=> $stable(monitor_route))
    else $error("monitor route changed without write");
  AST_UFLAGS: assert property (wr3 |=> {user_flag_high, user_flag_low} == $past(reg_wdata[7:6]))
    else $error("user flags wrong");

  cover property (rd1 ##1 reg_rdata[3]);
  cover property (wr3 && reg_wdata[3:0] > 4'h9);
  cover property (rd0 ##1 reg_rdata[4]);
endmodule
bind bafe_status_regs bafe_status_regs_monitor #(.PART_KIND(PART_KIND)) u_mon (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .wake_polarity_select(wake_polarity_select), .wake_pin_above(wake_pin_above),
  .charge_overcurrent_cond(charge_overcurrent_cond), .monitor_route(monitor_route),
  .user_flag_high(user_flag_high), .user_flag_low(user_flag_low));
`default_nettype wire

// File: test/battery_afe_status_mux_regs_tb_top.sv
// self-checking testbench for the status and monitor-select registers
`timescale 1ns/1ps
`default_nettype none
module battery_afe_status_mux_regs_tb_top;
  logic       clk, rst, pol, lme, wake, wr, rd, rvalid, uh, ul;
  logic [5:0] fc;
  logic [7:0] addr, wdata, rdata, d;
  logic [3:0] route;
  int         n_errors, compares, b, c;

  // fc index matches the fault bit; fc[3] stands for a heavy load
  bafe_status_regs #(.PART_KIND(1'b1)) dut (
    .clk(clk), .rst(rst), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdata), .reg_rvalid(rvalid), .wake_polarity_select(pol),
    .load_monitor_enable(lme), .wake_pin_above(wake), .ext_overtemp_cond(fc[5]),
    .int_overtemp_cond(fc[4]), .load_heavy_cond(fc[3]), .discharge_short_cond(fc[2]),
    .discharge_overcurrent_cond(fc[1]), .charge_overcurrent_cond(fc[0]),
    .monitor_route(route), .user_flag_high(uh), .user_flag_low(ul));
  bafe_host_model host (
    .clk(clk), .reg_rdata(rdata), .reg_rvalid(rvalid), .reg_addr(addr),
    .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, d);
    check(d, exp);
  endtask
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task final_report;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge clk);
    n_errors++;
    final_report;
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    {rst, pol, lme, wake, fc} = {1'b1, 9'h000};
    n_errors = 0;
    compares = 0;
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    rchk(8'h03, 8'h00);
    check({4'h0, route}, 8'h00);
    for (b = 0; b < 4; b++) begin
      {pol, wake} = b[1:0];
      hold(4);
      rchk(8'h00, {2'h0, 1'b1, b[1] ~^ b[0], 4'h0});
    end
    host.wr(8'h00, 8'hff);
    rchk(8'h00, 8'h30);
    for (b = 0; b < 6; b++) if (b != 3) begin
      fc[b] = 1'b1;
      hold(4);
      rchk(8'h01, 8'h01 << b);
      host.wr(8'h01, 8'h00);
      rchk(8'h01, 8'h01 << b);
      fc[b] = 1'b0;
      hold(4);
      rchk(8'h01, 8'h01 << b);
      rchk(8'h01, 8'h00);
    end
    lme = 1'b1;
    fc = 6'h0a;
    hold(4);
    rchk(8'h01, 8'h0a);
    fc = 6'h02;
    hold(4);
    rchk(8'h01, 8'h0a);
    rchk(8'h01, 8'h02);
    fc = 6'h00;
    hold(4);
    rchk(8'h01, 8'h02);
    lme = 1'b0;
    fc = 6'h0c;
    hold(4);
    rchk(8'h01, 8'h04);
    fc = 6'h00;
    hold(4);
    rchk(8'h01, 8'h04);
    for (c = 0; c < 16; c++) begin
      host.wr(8'h03, {c[1:0], 2'h0, c[3:0]});
      rchk(8'h03, {c[1:0], 2'h0, c[3:0]});
      check({4'h0, route}, (c > 9) ? 8'h00 : 8'(c));
      check({6'h0, uh, ul}, {6'h0, c[1:0]});
    end
    host.wr(8'h02, 8'hff);
    rchk(8'h02, 8'h00);
    rchk(8'h03, 8'hcf);
    final_report;
  end
endmodule
`default_nettype wire
